// ---- design/fscm_fan_control.sv ----
`timescale 1ns/1ps
// Summary of operation
// R1 - Filter bit 7 set suppresses fan spin-up; resets to zero.
// R2 - Filter bits 6:5 pick duty step of 1, 2, 4 or 8 slots.
// R3 - Filter bits 4:2 pick sample rate, doubling per code; reset code 100.
// R4 - Filter bit 0 enables filtered ramping; bit 1 unused; both reset zero.
// R5 - Configuration bit 7 clear means software fan control.
// R6 - Software mode with bit 5 clear: duty follows speed config register.
// R7 - Duty code 0 to F gives code over fifteen of full duty.
// R8 - Software mode with bit 5 set selects RPM feedback mode.
// R9 - Software writes target tach count to the tach limit register.
// R10 - RPM mode raises duty when slow, lowers it when fast.
// R11 - Software computes count from 11250, RPM and range N of 2.
// R12 - RPM mode flags failure only when tach count reaches 255.
// R13 - RPM loop regulates over the upper duty range, 75 to 100 percent.
// R14 - Software keeps setpoint above speed seen at duty code 8.
// R15 - Setpoint is held as an 8-bit tach period count.
// R16 - Software scales counts by 1.5 or 2 for other fan types.
// R17 - Software programs loop settings before entering automatic mode.
// R18 - PWM period is 240 slots; duty is a count of high slots.
// R19 - Filtered mode moves stored duty one step toward target per update.
// R20 - RPM loop adjusts once per finished tach measurement.
// R21 - Filtered step clamps to target when nearer than one step.
module fscm_fan_control
   import fscm_pkg::*;
#(
   parameter int unsigned UPDATE_CYCLES = UPDATE_BASE_CYCLES,
   parameter int unsigned SPIN_CYCLES = SPINUP_CYCLES,
   parameter int unsigned TACH_CYCLES = TACH_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire fscm_reg_req_t regReq,
   output fscm_reg_rsp_t regRsp,
   input wire logic [7:0] autoTargetDuty,
   input wire logic tachPin,
   output logic pwmOut,
   output logic fanFail,
   output logic spinUpActive
);

   typedef struct packed {
      fscm_regs_t regs;
      logic [7:0] duty;
      logic [7:0] reading;
      logic [31:0] updCnt;
      logic [31:0] spinCnt;
      logic spinning;
      logic prevZero;
      logic failSticky;
      logic failNow;
      fscm_reg_rsp_t rsp;
   } fscm_state_t;

   fscm_state_t st;
   fscm_state_t next_st;
   fscm_mode_t mode;
   logic tachDone;
   logic [7:0] tachResult;
   logic [7:0] target;
   logic [7:0] rampStep;
   logic [7:0] pwmDuty;
   logic updTick;
   logic failEvent;
   logic [31:0] updPeriod;

   // ------------------------------------------------------------
   // Update period from the sample rate code
   // ------------------------------------------------------------
   function automatic logic [31:0] rate_period(input logic [2:0] code);
      logic [31:0] base;
      base = 32'(UPDATE_CYCLES);
      if (code >= RATE_CODE_DEFAULT)
         rate_period = base >> (code - RATE_CODE_DEFAULT); // [R3]
      else
         rate_period = base << (RATE_CODE_DEFAULT - code); // [R3]
   endfunction

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   fscm_tach_meter #(
      .TICK_CYCLES(TACH_CYCLES)
   ) u_tach (
      .clk(clk),
      .rst(rst),
      .tachPin(tachPin),
      .speedRange(st.regs.fanChar[CHAR_RANGE_HI:CHAR_RANGE_LO]),
      .done(tachDone),
      .result(tachResult)
   );

   // Spin-up forces full duty for the whole spin-up time
   assign pwmDuty = st.spinning ? DUTY_FULL : st.duty;

   fscm_pwm_slots #(
      .SLOT_CYCLES(PWM_SLOT_CYCLES)
   ) u_pwm (
      .clk(clk),
      .rst(rst),
      .duty(pwmDuty),
      .invert(st.regs.config1[CFG1_INVERT_BIT]),
      .pwmOut(pwmOut)
   );

   // ------------------------------------------------------------
   // Mode and target selection
   // ------------------------------------------------------------
   always_comb
   begin
      if (st.regs.config1[CFG1_AUTO_BIT])
         mode = FSCM_MODE_AUTO;
      else if (st.regs.config1[CFG1_RPM_BIT]) // [R5] [R8]
         mode = FSCM_MODE_RPM;
      else
         mode = FSCM_MODE_DUTY; // [R6]
      rampStep = 8'h01 << st.regs.filter[FILT_RAMP_HI:FILT_RAMP_LO]; // [R2]
      updPeriod = rate_period(st.regs.filter[FILT_RATE_HI:FILT_RATE_LO]);
      updTick = (st.updCnt == 32'h0000_0000);
      target = DUTY_FULL;
      unique case (mode)
         FSCM_MODE_AUTO:
            target = (autoTargetDuty > DUTY_FULL) ? DUTY_FULL : autoTargetDuty;
         FSCM_MODE_DUTY:
            target = 8'(st.regs.speedConfig[3:0]) * DUTY_CODE_STEP; // [R7]
         FSCM_MODE_RPM:
            target = st.duty;
      endcase
      // RPM mode has no underspeed limit; only an overranged count fails
      if (mode == FSCM_MODE_RPM)
         failEvent = tachDone && tachResult == TACH_MAX; // [R12]
      else
         failEvent = tachDone && tachResult > st.regs.tachLimit;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.rsp.valid = 1'b0;

      // ------------------------------------------------------------
      // Register writes
      // ------------------------------------------------------------
      if (regReq.wrEn)
      begin
         unique case (regReq.addr)
            ADDR_CONFIG1:
               next_st.regs.config1 = regReq.wrData;
            ADDR_TACH_LIMIT:
               next_st.regs.tachLimit = regReq.wrData; // [R9] [R15]
            ADDR_FAN_CHAR:
               next_st.regs.fanChar = regReq.wrData;
            ADDR_SPEED_CONFIG:
               next_st.regs.speedConfig = regReq.wrData;
            ADDR_FILTER:
               next_st.regs.filter = regReq.wrData & FILTER_WRITE_MASK; // [R4]
            default:
               next_st.regs = st.regs;
         endcase
      end

      // ------------------------------------------------------------
      // Register reads: data one cycle after the strobe
      // ------------------------------------------------------------
      if (regReq.rdEn)
      begin
         next_st.rsp.valid = 1'b1;
         unique case (regReq.addr)
            ADDR_CONFIG1:
               next_st.rsp.data = st.regs.config1;
            ADDR_STATUS:
               next_st.rsp.data = 8'(st.failSticky) << STATUS_FAIL_BIT;
            ADDR_SPEED_READING:
               next_st.rsp.data = st.reading;
            ADDR_TACH_LIMIT:
               next_st.rsp.data = st.regs.tachLimit;
            ADDR_FAN_CHAR:
               next_st.rsp.data = st.regs.fanChar;
            ADDR_SPEED_CONFIG:
               next_st.rsp.data = st.regs.speedConfig;
            ADDR_FILTER:
               next_st.rsp.data = st.regs.filter;
            default:
               next_st.rsp.data = 8'h00;
         endcase
      end

      // ------------------------------------------------------------
      // Sample-rate timer for filtered updates
      // ------------------------------------------------------------
      if (updTick || st.updCnt > updPeriod)
         next_st.updCnt = updPeriod;
      else
         next_st.updCnt = st.updCnt - 32'h0000_0001;

      // ------------------------------------------------------------
      // Duty tracking per mode
      // ------------------------------------------------------------
      unique case (mode)
         FSCM_MODE_AUTO:
         begin
            if (!st.regs.filter[FILT_ENABLE_BIT])
               next_st.duty = target; // [R4]
            else if (updTick) // [R19]
            begin
               if (target > st.duty)
               begin
                  if (target - st.duty < rampStep) // [R21]
                     next_st.duty = target;
                  else
                     next_st.duty = st.duty + rampStep; // [R2]
               end
               else if (target < st.duty)
               begin
                  if (st.duty - target < rampStep) // [R21]
                     next_st.duty = target;
                  else
                     next_st.duty = st.duty - rampStep;
               end
            end
         end
         FSCM_MODE_DUTY:
            next_st.duty = target; // [R6] [R7]
         FSCM_MODE_RPM:
         begin
            // Bigger count means a longer period, so the fan is slow
            if (tachDone) // [R20]
            begin
               if (tachResult > st.regs.tachLimit) // [R10]
                  next_st.duty = (st.duty >= DUTY_FULL) ? DUTY_FULL : st.duty + RPM_DUTY_STEP;
               else if (tachResult < st.regs.tachLimit) // [R10]
                  next_st.duty = (st.duty <= RPM_DUTY_MIN) ? RPM_DUTY_MIN : st.duty - RPM_DUTY_STEP; // [R13]
            end
            if (st.duty < RPM_DUTY_MIN) // [R13]
               next_st.duty = RPM_DUTY_MIN;
         end
      endcase

      // ------------------------------------------------------------
      // Tach reading and fault flag
      // ------------------------------------------------------------
      if (tachDone)
      begin
         next_st.reading = tachResult;
         next_st.failNow = failEvent;
      end
      if (regReq.rdEn && regReq.addr == ADDR_STATUS)
         next_st.failSticky = 1'b0;
      if (failEvent)
         next_st.failSticky = 1'b1; // Set wins over the read clear

      // ------------------------------------------------------------
      // Spin-up on start from zero duty or on a failed measurement
      // ------------------------------------------------------------
      // Remember last cycle's duty, so a step from zero is seen one cycle on
      next_st.prevZero = (st.duty == 8'h00);
      if (st.spinning)
      begin
         if (st.spinCnt == 32'h0000_0000 || st.regs.filter[FILT_SPINUP_DIS_BIT])
            next_st.spinning = 1'b0;
         else
            next_st.spinCnt = st.spinCnt - 32'h0000_0001;
      end
      else if (!st.regs.filter[FILT_SPINUP_DIS_BIT]) // [R1]
      begin
         if ((st.prevZero && st.duty != 8'h00) || failEvent)
         begin
            next_st.spinning = 1'b1;
            next_st.spinCnt = 32'(SPIN_CYCLES - 1);
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st <= '0;
         st.regs.config1 <= CONFIG1_RESET;
         st.regs.filter <= FILTER_RESET; // [R1] [R3] [R4]
         st.regs.tachLimit <= TACH_LIMIT_RESET;
         st.regs.fanChar <= FAN_CHAR_RESET;
         st.regs.speedConfig <= SPEED_CONFIG_RESET;
         st.prevZero <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign regRsp = st.rsp;
   assign fanFail = st.failNow;
   assign spinUpActive = st.spinning;

endmodule

// ---- design/fscm_pwm_slots.sv ----
`timescale 1ns/1ps
module fscm_pwm_slots
   import fscm_pkg::*;
#(
   parameter int unsigned SLOT_CYCLES = PWM_SLOT_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] duty,
   input wire logic invert,
   output logic pwmOut
);

   typedef struct packed {
      logic [15:0] pre;
      logic [7:0] slot;
      logic out;
   } fscm_pwm_state_t;

   fscm_pwm_state_t st;
   fscm_pwm_state_t next_st;

   // ------------------------------------------------------------
   // Period of 240 slots, high for duty slots, low for them when invert is set
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      if (st.pre >= 16'(SLOT_CYCLES - 1))
      begin
         next_st.pre = '0;
         if (st.slot >= 8'(PWM_SLOT_COUNT - 1))
            next_st.slot = '0;
         else
            next_st.slot = st.slot + 8'h01;
      end
      else
      begin
         next_st.pre = st.pre + 16'h0001;
      end
      next_st.out = invert ^ (st.slot < duty); // [R18]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign pwmOut = st.out;

endmodule

// ---- design/fscm_tach_meter.sv ----
`timescale 1ns/1ps
module fscm_tach_meter
   import fscm_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TACH_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tachPin,
   input wire logic [1:0] speedRange,
   output logic done,
   output logic [7:0] result
);

   typedef struct packed {
      logic [1:0] sync;
      logic tachPrev;
      logic [1:0] edgeCnt;
      logic [15:0] pre;
      logic [2:0] rangeCnt;
      logic [7:0] count;
      logic done;
      logic [7:0] result;
   } fscm_tach_state_t;

   fscm_tach_state_t st;
   fscm_tach_state_t next_st;
   logic rise;
   logic tick;

   // ------------------------------------------------------------
   // Period count: first to third tach edge, oscillator / N
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.sync = {st.sync[0], tachPin};
      next_st.tachPrev = st.sync[1];
      next_st.done = 1'b0;
      rise = st.sync[1] & ~st.tachPrev;
      tick = 1'b0;
      if (st.pre >= 16'(TICK_CYCLES - 1))
      begin
         next_st.pre = '0;
         if (st.rangeCnt >= 3'((1 << speedRange) - 1))
         begin
            next_st.rangeCnt = '0;
            tick = 1'b1;
         end
         else
         begin
            next_st.rangeCnt = st.rangeCnt + 3'h1;
         end
      end
      else
      begin
         next_st.pre = st.pre + 16'h0001;
      end
      if (tick && st.count != TACH_MAX)
         next_st.count = st.count + 8'h01;
      if (st.count == TACH_MAX)
      begin
         // Overrange also covers a fan that never reaches its second edge
         next_st.done = 1'b1;
         next_st.result = TACH_MAX;
         next_st.count = '0;
         next_st.edgeCnt = '0;
      end
      else if (rise)
      begin
         next_st.edgeCnt = st.edgeCnt + 2'h1;
         if (st.edgeCnt == 2'h0)
            next_st.count = '0;
         if (st.edgeCnt == 2'h2)
         begin
            next_st.done = 1'b1;
            next_st.result = st.count;
            next_st.count = '0;
            next_st.edgeCnt = '0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Tach idles high, so the edge detector starts high to avoid a false edge
         st <= '0;
         st.sync <= 2'h3;
         st.tachPrev <= 1'b1;
      end
      else
         st <= next_st;
   end

   assign done = st.done;
   assign result = st.result;

endmodule

// ---- dv/fscm_fan_control_bench.sv ----
`timescale 1ns/1ps
module fscm_fan_control_bench;
   import fscm_pkg::*;
   localparam int PER = PWM_SLOT_COUNT * PWM_SLOT_CYCLES;
   localparam logic [15:0] SC = 16'(PWM_SLOT_CYCLES);
   logic clk;
   logic rst;
   fscm_reg_req_t regReq;
   fscm_reg_rsp_t regRsp;
   logic [7:0] autoTargetDuty;
   logic tachPin;
   logic pwmOut;
   logic fanFail;
   logic spinUpActive;
   logic [15:0] tachPeriod;
   logic tachStall;
   logic [15:0] hi;
   int failures;
   int checked;
   fscm_fan_control #(.UPDATE_CYCLES(200), .SPIN_CYCLES(50), .TACH_CYCLES(4)) fscm_fan_control_inst (
      .clk(clk), .rst(rst), .regReq(regReq), .regRsp(regRsp), .autoTargetDuty(autoTargetDuty),
      .tachPin(tachPin), .pwmOut(pwmOut), .fanFail(fanFail), .spinUpActive(spinUpActive));
   fscm_fan_model fscm_fan_model_inst (.clk(clk), .period(tachPeriod), .stall(tachStall), .tachPin(tachPin));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
      @(posedge clk);
      regReq <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
      @(posedge clk);
      regReq <= '0;
      #1;
      cmp(regRsp.valid, 1'b1);
      d = regRsp.data;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      cmp(d, exp);
   endtask
   task automatic duty(output logic [15:0] h);
      h = 16'h0000;
      repeat (PER)
      begin
         @(posedge clk);
         #1;
         h = h + {15'h0000, pwmOut === 1'b1};
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rdc(ADDR_CONFIG1, 8'h00);
      rdc(ADDR_FILTER, 8'h10);
      rdc(ADDR_TACH_LIMIT, 8'hFF);
      rdc(ADDR_FAN_CHAR, 8'h40);
      rdc(ADDR_SPEED_CONFIG, 8'h00);
      rdc(8'h7F, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_filter();
      logic [7:0] v;
      wr(ADDR_FILTER, 8'hFF);
      rdc(ADDR_FILTER, 8'hFD);
      for (int i = 0; i < 8; i++)
      begin
         v = 8'h80 | 8'(i << 2) | 8'((i & 3) << 5);
         wr(ADDR_FILTER, v);
         rdc(ADDR_FILTER, v);
      end
      wr(ADDR_FILTER, 8'h80);
      $display("filter test done");
   endtask
   task automatic t_duty();
      logic [7:0] codes[3] = '{8'h00, 8'h08, 8'h0F};
      foreach (codes[i])
      begin
         wr(ADDR_SPEED_CONFIG, codes[i]);
         repeat (PER) @(posedge clk);
         duty(hi);
         cmp(hi, 16'(codes[i]) * 16'(DUTY_CODE_STEP) * SC);
      end
      wr(ADDR_CONFIG1, 8'h08);
      repeat (4) @(posedge clk);
      #1 cmp(pwmOut, 1'b0);
      wr(ADDR_CONFIG1, 8'h00);
      $display("duty test done");
   endtask
   task automatic t_spin();
      bit seen;
      wr(ADDR_SPEED_CONFIG, 8'h00);
      wr(ADDR_FILTER, 8'h10);
      wr(ADDR_SPEED_CONFIG, 8'h01);
      seen = 0;
      for (int i = 0; i < 8 && !seen; i++)
         @(posedge clk) seen = spinUpActive;
      cmp(seen, 1'b1);
      for (int i = 0; i < 80 && seen; i++)
         @(posedge clk) seen = spinUpActive;
      cmp(seen, 1'b0);
      wr(ADDR_SPEED_CONFIG, 8'h00);
      wr(ADDR_FILTER, 8'h90);
      wr(ADDR_SPEED_CONFIG, 8'h01);
      repeat (20) @(posedge clk) seen |= spinUpActive;
      cmp(seen, 1'b0);
      $display("spin-up test done");
   endtask
   task automatic t_auto();
      autoTargetDuty <= 8'd120;
      wr(ADDR_FILTER, 8'h90);
      wr(ADDR_CONFIG1, 8'h80);
      repeat (PER) @(posedge clk);
      duty(hi);
      cmp(hi, 16'd120 * SC);
      wr(ADDR_FILTER, 8'hE1);
      autoTargetDuty <= 8'd240;
      duty(hi);
      cmp(hi >= 16'd120 * SC && hi <= 16'd136 * SC, 1'b1);
      @(posedge clk) autoTargetDuty <= 8'd125;
      wr(ADDR_FILTER, 8'hFD);
      repeat (PER) @(posedge clk);
      duty(hi);
      cmp(hi, 16'd125 * SC);
      $display("auto test done");
   endtask
   task automatic t_rpm();
      bit seen;
      wr(ADDR_CONFIG1, 8'h20);
      wr(ADDR_TACH_LIMIT, 8'h14);
      repeat (2000) @(posedge clk);
      duty(hi);
      cmp(hi, 16'd180 * SC);
      tachPeriod <= 16'h00A0;
      repeat (6000) @(posedge clk);
      duty(hi);
      cmp(hi > 16'd180 * SC, 1'b1);
      cmp(fanFail, 1'b0);
      tachStall <= 1'b1;
      seen = 0;
      for (int i = 0; i < 6000 && !seen; i++)
         @(posedge clk) seen = fanFail;
      cmp(seen, 1'b1);
      rdc(ADDR_SPEED_READING, 8'hFF);
      rdc(ADDR_STATUS, 8'h02);
      rdc(ADDR_STATUS, 8'h00);
      $display("rpm test done");
   endtask
   initial
   begin
      repeat (98000) @(posedge clk);
      failures++;
      results();
   end
   initial
   begin
      rst = 1'b1;
      regReq = '0;
      autoTargetDuty = 8'h00;
      tachPeriod = 16'h0028;
      tachStall = 1'b0;
      failures = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_filter();
      t_duty();
      t_spin();
      t_auto();
      t_rpm();
      results();
   end
endmodule

// ---- dv/fscm_fan_control_checker.sv ----
`timescale 1ns/1ps
module fscm_fan_control_checker
   import fscm_pkg::*;
#(
   parameter int unsigned UPDATE_CYCLES = 200,
   parameter int unsigned SPIN_CYCLES = 50,
   parameter int unsigned TACH_CYCLES = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire fscm_reg_req_t regReq,
   input wire fscm_reg_rsp_t regRsp,
   input wire logic [7:0] autoTargetDuty,
   input wire logic tachPin,
   input wire logic pwmOut,
   input wire logic fanFail,
   input wire logic spinUpActive
);
   // ------------------------------------------------------------
   // Shadow of mode bits
   // ------------------------------------------------------------
   // Full period plus margin, since duty may be taken at period start
   localparam int AGE_MIN = PWM_SLOT_COUNT * PWM_SLOT_CYCLES + 10;
   logic [7:0] cfg;
   logic [3:0] code;
   logic spinOff;
   logic dutyMode;
   logic wrMode;
   int spinCnt;
   int age;
   assign dutyMode = !cfg[CFG1_AUTO_BIT] && !cfg[CFG1_RPM_BIT];
   assign wrMode = regReq.wrEn && (regReq.addr == ADDR_CONFIG1 || regReq.addr == ADDR_SPEED_CONFIG);
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg <= CONFIG1_RESET;
         code <= 4'h0;
         spinOff <= 1'b0;
      end
      else if (regReq.wrEn)
      begin
         if (regReq.addr == ADDR_CONFIG1)
            cfg <= regReq.wrData;
         if (regReq.addr == ADDR_SPEED_CONFIG)
            code <= regReq.wrData[3:0];
         if (regReq.addr == ADDR_FILTER)
            spinOff <= regReq.wrData[FILT_SPINUP_DIS_BIT];
      end
   end
   always_ff @(posedge clk)
   begin
      spinCnt <= (rst || !spinUpActive) ? 0 : spinCnt + 1;
      age <= (rst || wrMode || !dutyMode || spinUpActive) ? 0 : age + 1;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   read_answer_a: assert property (regReq.rdEn |=> regRsp.valid)
      else $error("read not answered next cycle");
   idle_valid_a: assert property (!regReq.rdEn |=> !regRsp.valid)
      else $error("valid without read");
   data_hold_a: assert property (!regReq.rdEn |=> $stable(regRsp.data))
      else $error("read data moved without read");
   filter_bit1_a: assert property (regReq.rdEn && regReq.addr == ADDR_FILTER |=> !regRsp.data[1])
      else $error("unused filter bit read as one");
   spin_off_a: assert property (spinOff && $past(spinOff, 2) |-> !spinUpActive)
      else $error("spin-up while disabled");
   spin_len_a: assert property (spinCnt <= SPIN_CYCLES + 2)
      else $error("spin-up window too long");
   spin_start_a: assert property (regReq.wrEn && regReq.addr == ADDR_SPEED_CONFIG && regReq.wrData[3:0] != 4'h0
      && code == 4'h0 && dutyMode && !spinOff |-> ##[1:4] spinUpActive)
      else $error("no spin-up on start from zero duty");
   duty_zero_a: assert property (age > AGE_MIN && code == 4'h0 |-> pwmOut == cfg[CFG1_INVERT_BIT])
      else $error("output active at duty code zero");
   duty_full_a: assert property (age > AGE_MIN && code == 4'hF |-> pwmOut != cfg[CFG1_INVERT_BIT])
      else $error("output idle at full duty code");
   spin_c: cover property ($rose(spinUpActive));
   fail_c: cover property ($rose(fanFail));
   full_c: cover property (age > AGE_MIN && code == 4'hF);
endmodule
bind fscm_fan_control fscm_fan_control_checker #(
   .UPDATE_CYCLES(UPDATE_CYCLES),
   .SPIN_CYCLES(SPIN_CYCLES),
   .TACH_CYCLES(TACH_CYCLES)
) fscm_fan_control_checker_inst (
   .clk(clk), .rst(rst), .regReq(regReq), .regRsp(regRsp), .autoTargetDuty(autoTargetDuty),
   .tachPin(tachPin), .pwmOut(pwmOut), .fanFail(fanFail), .spinUpActive(spinUpActive)
);

// ---- dv/fscm_fan_model.sv ----
`timescale 1ns/1ps
module fscm_fan_model
(
   input wire logic clk,
   input wire logic [15:0] period,
   input wire logic stall,
   output logic tachPin
);
   // ------------------------------------------------------------
   // Tach source
   // ------------------------------------------------------------
   // Stalled rotor leaves the pulled-up tach line high
   logic [15:0] cnt = 16'h0000;
   initial tachPin = 1'b1;
   always @(posedge clk)
   begin
      cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
      tachPin <= stall | (cnt < (period >> 1));
   end
endmodule

// ---- shared/fscm_pkg.sv ----
package fscm_pkg;

   // ------------------------------------------------------------
   // Clock and time bases
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TACH_OSC_HZ = 11_250;
   localparam int unsigned TACH_TICK_CYCLES = CLK_HZ / TACH_OSC_HZ;
   localparam int unsigned PWM_HZ = 31_250;
   localparam int unsigned PWM_SLOT_COUNT = 240;
   localparam int unsigned PWM_SLOT_CYCLES = CLK_HZ / (PWM_HZ * PWM_SLOT_COUNT);
   localparam int unsigned UPDATE_DEFAULT_S = 1;
   localparam int unsigned UPDATE_BASE_CYCLES = CLK_HZ * UPDATE_DEFAULT_S;
   localparam int unsigned SPINUP_TIME_MS = 2000;
   localparam int unsigned SPINUP_CYCLES = (CLK_HZ / 1000) * SPINUP_TIME_MS;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG1 = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_SPEED_READING = 8'h08;
   localparam logic [7:0] ADDR_TACH_LIMIT = 8'h10;
   localparam logic [7:0] ADDR_FAN_CHAR = 8'h20;
   localparam logic [7:0] ADDR_SPEED_CONFIG = 8'h22;
   localparam logic [7:0] ADDR_FILTER = 8'h23;

   localparam int CFG1_AUTO_BIT = 7;
   localparam int CFG1_RPM_BIT = 5;
   localparam int CFG1_INVERT_BIT = 3;
   localparam int FILT_SPINUP_DIS_BIT = 7;
   localparam int FILT_RAMP_HI = 6;
   localparam int FILT_RAMP_LO = 5;
   localparam int FILT_RATE_HI = 4;
   localparam int FILT_RATE_LO = 2;
   localparam int FILT_ENABLE_BIT = 0;
   localparam int CHAR_RANGE_HI = 7;
   localparam int CHAR_RANGE_LO = 6;
   localparam int STATUS_FAIL_BIT = 1;

   localparam logic [7:0] CONFIG1_RESET = 8'h00;
   localparam logic [7:0] FILTER_RESET = 8'h10;
   localparam logic [7:0] FILTER_WRITE_MASK = 8'hFD;
   localparam logic [7:0] TACH_LIMIT_RESET = 8'hFF;
   localparam logic [7:0] FAN_CHAR_RESET = 8'h40;
   localparam logic [7:0] SPEED_CONFIG_RESET = 8'h00;
   localparam logic [2:0] RATE_CODE_DEFAULT = 3'h4;

   // ------------------------------------------------------------
   // Duty and tach figures
   // ------------------------------------------------------------
   localparam logic [7:0] DUTY_FULL = 8'hF0;
   localparam logic [7:0] DUTY_CODE_STEP = 8'h10;
   localparam logic [7:0] RPM_DUTY_MIN = 8'hB4;
   localparam logic [7:0] RPM_DUTY_STEP = 8'h01;
   localparam logic [7:0] TACH_MAX = 8'hFF;

   typedef struct packed {
      logic [7:0] config1;
      logic [7:0] filter;
      logic [7:0] tachLimit;
      logic [7:0] fanChar;
      logic [7:0] speedConfig;
   } fscm_regs_t;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } fscm_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } fscm_reg_rsp_t;

   typedef enum logic [1:0] {
      FSCM_MODE_AUTO,
      FSCM_MODE_DUTY,
      FSCM_MODE_RPM
   } fscm_mode_t;

endpackage
